//--- pgp_pkg.sv
// package of constants and types for the port 6 gpio block
package pgp_pkg;

    // =========================================================
    // widths
    localparam int unsigned PGP_PINS   = 8;
    localparam int unsigned PGP_AW     = 12;
    localparam int unsigned PGP_DW     = 32;
    localparam int unsigned PGP_SGSW   = 4;

    // =========================================================
    // register byte offsets
    localparam logic [11:0] PGP_OFS_LATCH  = 12'h000;
    localparam logic [11:0] PGP_OFS_DIR    = 12'h004;
    localparam logic [11:0] PGP_OFS_PULLUP = 12'h008;
    localparam logic [11:0] PGP_OFS_LCDCTL = 12'h00C;

    // =========================================================
    // reset values
    localparam logic [7:0] PGP_RST_LATCH  = 8'h00;
    localparam logic [7:0] PGP_RST_DIR    = 8'h00;
    localparam logic [7:0] PGP_RST_PULLUP = 8'h00;
    localparam logic [3:0] PGP_RST_SGS    = 4'h0;

    // =========================================================
    // read values and field positions
    localparam logic [7:0] PGP_DIR_READ   = 8'hFF;
    localparam int unsigned PGP_SGS_LSB   = 0;
    localparam int unsigned PGP_HI_LSB    = 4;

    // =========================================================
    // bus phase
    typedef enum logic [1:0] {
        PGP_IDLE,
        PGP_ACCESS
    } pgp_state_t;

endpackage

//--- pgp_pin.sv
// one port pin: function select, drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module pgp_pin (
    // configuration
    input  wire logic is_seg,
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic pullup_en,
    // segment source
    input  wire logic seg_level,
    // pin side
    output logic      pad_o,
    output logic      pad_oe_n,
    output logic      pad_pu
);
    always_comb begin
        if (is_seg) begin
            pad_o    = seg_level;
            pad_oe_n = 1'b0;
        end else begin
            pad_o    = latch;
            pad_oe_n = ~dir;
        end
        pad_pu = ~is_seg & ~dir & pullup_en;
    end
endmodule
`default_nettype wire

//--- pgp_top.sv
// port 6 gpio with pull-up control and lcd segment sharing
`timescale 1ns/1ps
`default_nettype none
module pgp_top (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [pgp_pkg::PGP_AW-1:0] paddr,
    input  wire logic [pgp_pkg::PGP_DW-1:0] pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [pgp_pkg::PGP_DW-1:0]     prdata,
    output logic                           pready,
    output logic                           pslverr,
    // lcd segment levels for segments 9..16
    input  wire logic [7:0]                seg_level,
    // pins
    input  wire logic [7:0]                pin_i,
    output logic [7:0]                     pin_o,
    output logic [7:0]                     pin_oe_n,
    output logic [7:0]                     pin_pu
);
    import pgp_pkg::*;

    // =========================================================
    // state
    pgp_state_t        st_q, st_d;
    logic [7:0]        latch_q, latch_d;
    logic [7:0]        dir_q, dir_d;
    logic [7:0]        pu_q, pu_d;
    logic [3:0]        sgs_q, sgs_d;
    logic [PGP_DW-1:0] rdata_q, rdata_d;
    logic              rdy_q, rdy_d;
    logic              err_q, err_d;
    logic [7:0]        po_q, po_d;
    logic [7:0]        poe_q, poe_d;
    logic [7:0]        ppu_q, ppu_d;
    logic [7:0]        pin_s_q;

    // =========================================================
    // segment decode
    logic       hi_gpio;
    logic       lo_gpio;
    logic [7:0] is_seg;
    logic [7:0] c_o;
    logic [7:0] c_oe_n;
    logic [7:0] c_pu;

    always_comb begin
        unique case (sgs_q)
            4'h0: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b1;
            end
            4'h1: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b1;
            end
            4'h2: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b1;
            end
            4'h3: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b0;
            end
            4'h4: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b0;
            end
            4'h5: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b0;
            end
            4'h6: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b0;
            end
            4'h7: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b0;
            end
            4'h8: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b0;
            end
            4'h9: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b0;
            end
            4'hA: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b0;
            end
            4'hB: begin
                hi_gpio = 1'b0;
                lo_gpio = 1'b1;
            end
            4'hC: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b1;
            end
            4'hD: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b1;
            end
            4'hE: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b1;
            end
            4'hF: begin
                hi_gpio = 1'b1;
                lo_gpio = 1'b1;
            end
        endcase
        is_seg  = {{4{~hi_gpio}}, {4{~lo_gpio}}};
    end

    // =========================================================
    // pin cells
    genvar g;
    generate
        for (g = 0; g < PGP_PINS; g++) begin : g_pin
            pgp_pin u_pin (
                .is_seg    (is_seg[g]),
                .dir       (dir_q[g]),
                .latch     (latch_q[g]),
                .pullup_en (pu_q[g]),
                .seg_level (seg_level[g]),
                .pad_o     (c_o[g]),
                .pad_oe_n  (c_oe_n[g]),
                .pad_pu    (c_pu[g])
            );
        end
    endgenerate

    // =========================================================
    // address decode
    logic       sel_latch;
    logic       sel_dir;
    logic       sel_pullup;
    logic       sel_lcdctl;
    logic       hit;

    always_comb begin
        sel_latch  = (paddr == PGP_OFS_LATCH);
        sel_dir    = (paddr == PGP_OFS_DIR);
        sel_pullup = (paddr == PGP_OFS_PULLUP);
        sel_lcdctl = (paddr == PGP_OFS_LCDCTL);
        hit        = sel_latch | sel_dir | sel_pullup | sel_lcdctl;
    end

    // =========================================================
    // bus phase
    logic       take;
    logic       wr_en;
    logic       rd_en;

    always_comb begin
        st_d  = st_q;
        rdy_d = 1'b0;
        err_d = 1'b0;
        take  = 1'b0;
        unique case (st_q)
            PGP_IDLE: begin
                // setup phase seen, access follows
                if (psel && !penable) begin
                    st_d = PGP_ACCESS;
                end
            end
            PGP_ACCESS: begin
                // answer one cycle into the access phase
                if (psel && penable && !rdy_q) begin
                    take  = 1'b1;
                    rdy_d = 1'b1;
                    err_d = ~hit;
                end else if (rdy_q) begin
                    st_d = PGP_IDLE;
                end
            end
        endcase
        // writes need byte lane 0
        wr_en = take & pwrite & hit & pstrb[0];
        rd_en = take & ~pwrite;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= PGP_IDLE;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
        end
    end

    // =========================================================
    // port registers
    always_comb begin
        latch_d = latch_q;
        dir_d   = dir_q;
        pu_d    = pu_q;
        if (wr_en && sel_latch) begin
            latch_d = pwdata[7:0];
        end
        if (wr_en && sel_dir) begin
            dir_d = pwdata[7:0];
        end
        if (wr_en && sel_pullup) begin
            pu_d = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= PGP_RST_LATCH;
            dir_q   <= PGP_RST_DIR;
            pu_q    <= PGP_RST_PULLUP;
        end else begin
            latch_q <= latch_d;
            dir_q   <= dir_d;
            pu_q    <= pu_d;
        end
    end

    // =========================================================
    // lcd port control
    always_comb begin
        sgs_d = sgs_q;
        if (wr_en && sel_lcdctl) begin
            sgs_d = pwdata[PGP_SGS_LSB +: PGP_SGSW];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sgs_q <= PGP_RST_SGS;
        end else begin
            sgs_q <= sgs_d;
        end
    end

    // =========================================================
    // input sampler
    logic [7:0] pin_s_d;

    always_comb begin
        pin_s_d = pin_i;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s_q <= 8'h00;
        end else begin
            pin_s_q <= pin_s_d;
        end
    end

    // =========================================================
    // read data
    logic [7:0] rb;
    logic [7:0] rb_latch;

    always_comb begin
        rb_latch = (dir_q & latch_q) | (~dir_q & pin_s_q);
        if (sel_latch) begin
            rb = rb_latch;
        end else if (sel_dir) begin
            rb = PGP_DIR_READ;
        end else if (sel_pullup) begin
            rb = pu_q;
        end else if (sel_lcdctl) begin
            rb = {4'h0, sgs_q};
        end else begin
            rb = 8'h00;
        end
        rdata_d = rdata_q;
        if (rd_en) begin
            rdata_d = {24'h000000, rb};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // =========================================================
    // pin outputs
    always_comb begin
        po_d  = c_o;
        poe_d = c_oe_n;
        ppu_d = c_pu;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            po_q  <= 8'h00;
            poe_q <= 8'hFF;
            ppu_q <= 8'h00;
        end else begin
            po_q  <= po_d;
            poe_q <= poe_d;
            ppu_q <= ppu_d;
        end
    end

    // =========================================================
    // outputs
    assign prdata   = rdata_q;
    assign pready   = rdy_q;
    assign pslverr  = err_q;
    assign pin_o    = po_q;
    assign pin_oe_n = poe_q;
    assign pin_pu   = ppu_q;

endmodule
`default_nettype wire

//--- pgp_monitor.sv
// checker of the port 6 gpio block
`timescale 1ns/1ps
`default_nettype none
module pgp_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // pins
    input wire logic [7:0]  pin_oe_n,
    input wire logic [7:0]  pin_pu
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_late_ready: assert property (s_setup ##1 penable |=> pready)
        else $error("late ready");
    a_ready_once: assert property (pready |=> !pready) else $error("held");
    a_err_ready: assert property (pslverr |-> pready) else $error("lone err");
    a_bad_addr: assert property (s_done ##0 (paddr > 12'h00C) |-> pslverr)
        else $error("unmapped taken");
    a_dir_ones: assert property (
        s_done ##0 (!pwrite && paddr == 12'h004) |-> prdata == 32'hFF)
        else $error("direction read");
    a_rd_upper: assert property (
        s_done ##0 !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper bits");
    a_pu_driven: assert property ((pin_pu & ~pin_oe_n) == 8'h00)
        else $error("pull-up on driven pin");
    a_reset_pins: assert property (
        $rose(presetn) |-> pin_pu == 8'h00 && pin_oe_n == 8'hFF)
        else $error("pins after reset");
endmodule
bind pgp_top pgp_monitor u_mon (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pready   (pready),
    .pslverr  (pslverr),
    .paddr    (paddr),
    .prdata   (prdata),
    .pin_oe_n (pin_oe_n),
    .pin_pu   (pin_pu)
);
`default_nettype wire

//--- pgp_pads.sv
// pad model: outside drivers, pull-ups and floating pins
`timescale 1ns/1ps
`default_nettype none
module pgp_pads (
    // port drive
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pin_pu,
    // outside drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // level seen by the port
    output logic      [7:0] pin_i
);
    // an outside driver wins on a released pin, else the pull-up lifts it, else it reads back the inverse of pin_o
    assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext_en & ext_val)
                 | (pin_oe_n & ~ext_en & (pin_pu | ~pin_o));
endmodule
`default_nettype wire

//--- pgp_top_test.sv
// self-checking bench of the port 6 gpio block
`timescale 1ns/1ps
`default_nettype none
module pgp_top_test;
    import pgp_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0;
    logic        penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
    logic [3:0]  pstrb = 4'hF;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  seg_level = 8'h0, ext_en = 8'hFF, ext_val = 8'h3C;
    logic [7:0]  pin_i, pin_o, pin_oe_n, pin_pu;
    int          n_mismatch = 0, checks = 0;
    initial forever #5 pclk = ~pclk;
    pgp_top u_dut (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .pstrb     (pstrb),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .seg_level (seg_level),
        .pin_i     (pin_i),
        .pin_o     (pin_o),
        .pin_oe_n  (pin_oe_n),
        .pin_pu    (pin_pu)
    );
    pgp_pads u_pad (
        .pin_o    (pin_o),
        .pin_oe_n (pin_oe_n),
        .pin_pu   (pin_pu),
        .ext_en   (ext_en),
        .ext_val  (ext_val),
        .pin_i    (pin_i)
    );
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge pclk);
        if (i == 20) begin
            n_mismatch++;
            end_sim;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdc(input logic [11:0] a, logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic pins(input logic [7:0] m, o, oe, pu);
        repeat (3) @(posedge pclk);
        chk(32'(pin_o & m), 32'(o));
        chk(32'(pin_oe_n), 32'(oe));
        chk(32'(pin_pu), 32'(pu));
    endtask
    task automatic t_gpio;
        rdc(PGP_OFS_LATCH, 32'h3C);
        rdc(PGP_OFS_PULLUP, 32'h00);
        apb(1'h1, PGP_OFS_DIR, 32'hFF);
        rdc(PGP_OFS_LATCH, 32'h00);
        apb(1'h1, PGP_OFS_LATCH, 32'hA5);
        apb(1'h1, PGP_OFS_DIR, 32'hF0);
        ext_en <= 8'h03;
        apb(1'h1, PGP_OFS_PULLUP, 32'h3C);
        rdc(PGP_OFS_DIR, 32'hFF);
        rdc(PGP_OFS_LATCH, 32'hAC);
        rdc(PGP_OFS_PULLUP, 32'h3C);
        pins(8'hF0, 8'hA0, 8'h0F, 8'h0C);
        apb(1'h1, 12'h010, 32'hFF);
        chk(32'(err), 32'h1);
    endtask
    task automatic t_seg;
        logic [7:0] m;
        seg_level <= 8'h5A;
        for (int s = 0; s < 16; s++) begin
            m[7:4] = {4{s[3:2] == 2'h1 || s[3:2] == 2'h2}};
            m[3:0] = {4{!(s[3:1] == 3'h0 || s == 2 || s == 11
                        || s[3:2] == 2'h3)}};
            apb(1'h1, PGP_OFS_LCDCTL, 32'(s));
            pins(m | 8'hF0, (8'h5A & m) | (8'hA0 & ~m), 8'h0F & ~m,
                 8'h0C & ~m);
        end
    endtask
    task automatic t_reset;
        apb(1'h1, PGP_OFS_PULLUP, 32'hFF);
        apb(1'h1, PGP_OFS_DIR, 32'h00);
        pins(8'h00, 8'h00, 8'hFF, 8'hFF);
        rdc(PGP_OFS_LATCH, 32'hFC);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        pins(8'hFF, 8'h00, 8'hFF, 8'h00);
        rdc(PGP_OFS_PULLUP, 32'h00);
        rdc(PGP_OFS_LCDCTL, 32'(PGP_RST_SGS));
        apb(1'h1, PGP_OFS_DIR, 32'hFF);
        pstrb <= 4'h0;
        apb(1'h1, PGP_OFS_LATCH, 32'h96);
        pstrb <= 4'hF;
        rdc(PGP_OFS_LATCH, 32'h00);
        apb(1'h1, PGP_OFS_LATCH, 32'h96);
        rdc(PGP_OFS_LATCH, 32'h96);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        t_gpio;
        t_seg;
        t_reset;
        end_sim;
    end
endmodule
`default_nettype wire
